// [hdl/imp_pkg.sv]
// shared constants, types and register map of the indexer manual positioning block
package imp_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DIVISION = 8'h04;
    localparam logic [7:0] ADDR_TLDELAY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_INT_STAT = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    // control register fields
    localparam int CTRL_INDEXER = 0;
    localparam int CTRL_SUBMODE = 1;
    localparam int CTRL_CCW = 2;
    localparam int CTRL_SPEEDSRC = 3;
    localparam int CTRL_TWOSTN = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [7:0] DIVISION_RESET = 8'h08;
    localparam logic [15:0] TLDELAY_RESET = 16'h0000;
    // interrupt bits
    localparam int INT_DONE = 0;
    localparam int INT_WARN = 1;
    localparam int INT_REFUSED = 2;
    localparam int INT_W = 3;
    localparam logic [2:0] INT_RESET = 3'h0;
    localparam logic [7:0] ENTRY_ONE = 8'h01;
    // ----------------------------------------
    // timing: torque limit delay counts in milliseconds
    // ----------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TL_UNIT_US = 1000;
    localparam int TL_UNIT_CYCLES = CLK_MHZ * TL_UNIT_US;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_AUTO = 2'b01,
        ST_JOG = 2'b10,
        ST_SETTLE = 2'b11
    } imp_state_t;
    typedef struct packed {
        logic active;
        logic positioning;
        logic ccw;
        logic directSpeed;
        logic [7:0] station;
        logic [7:0] entry;
        logic [15:0] speed;
    } imp_cmd_t;
    localparam imp_cmd_t CMD_IDLE = '0;
    typedef struct packed {
        logic start;
        logic modeOne;
        logic modeTwo;
    } imp_fb_t;
endpackage

// [hdl/imp_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module imp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    // output follows only once stages two and three agree
    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s3;
        end
    end

    // s1 is read by s2 only, to keep metastability contained
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule

// [hdl/imp_delay_timer.sv]
// delay timer: raises expired once arm has held for delay units
`timescale 1ns/10ps
module imp_delay_timer #(
    parameter int TICK = 50000
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic arm,
    input wire logic [15:0] delay,
    output logic expired
);
    localparam logic [15:0] TICK_LAST = 16'(TICK - 1);
    logic [15:0] prescale;
    logic [15:0] units;
    logic [15:0] next_prescale;
    logic [15:0] next_units;
    logic next_expired;

    // a drop of arm restarts the whole delay
    always_comb begin
        next_prescale = prescale;
        next_units = units;
        next_expired = expired;
        if (!arm) begin
            next_prescale = '0;
            next_units = '0;
            next_expired = 1'b0;
        end else if (units == delay) begin
            next_expired = 1'b1;
        end else if (prescale == TICK_LAST) begin
            next_prescale = '0;
            next_units = units + 16'h0001;
        end else begin
            next_prescale = prescale + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prescale <= '0;
            units <= '0;
            expired <= 1'b0;
        end else begin
            prescale <= next_prescale;
            units <= next_units;
            expired <= next_expired;
        end
    end
endmodule

// [hdl/imp_top.sv]
// indexer positioning sequencer: remote-word automatic mode and the two jog modes
// Function
// - warn when requested station is at or above the division count
// - start is ignored while moving; master restarts after movement done
// - after in-position, switch to stop torque limit after programmed delay
// - after power-on, in-position rises when position is within a station range
// - direct speed only with two stations; acceleration from table entry one
// - manual modes ignore the station select and speed select bits
// - submode bit clear gives indexer jog, set gives plain jog
// - direction bit clear numbers stations clockwise, set counter-clockwise; automatic moves always command ccw clear
// - manual modes take jog speed and ramps from table entry one
// - indexer jog runs while start held, then stops at reachable station
// - plain jog runs while start held, then decelerates anywhere
// - automatic mode takes target station from the target word at start
// - speed source bit picks table entry or direct speed from the word
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module imp_top #(
    parameter int TL_TICK = imp_pkg::TL_UNIT_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic motionStartBit,
    input wire logic modeSelectOne,
    input wire logic modeSelectTwo,
    input wire logic [15:0] targetStationWord,
    input wire logic [15:0] tableOrSpeedWord,
    input wire logic inRangeAny,
    input wire logic servoDone,
    input wire logic [7:0] stopStation,
    output imp_pkg::imp_cmd_t motionCmd,
    output logic movementDoneFlag,
    output logic inPositionFlag,
    output logic nextStationWarning,
    output logic torqueLimitStop,
    output logic irq
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    imp_pkg::imp_fb_t fbSync;
    logic [31:0] wordSync;
    logic [15:0] targetSync;
    logic [15:0] speedWordSync;

    imp_sync #(.W(3)) u_bits (
        .clk(clk),
        .nrst(nrst),
        .din({motionStartBit, modeSelectOne, modeSelectTwo}),
        .dout(fbSync)
    );

    // words are held steady by the master ahead of start, so tearing is harmless
    imp_sync #(.W(32)) u_words (
        .clk(clk),
        .nrst(nrst),
        .din({targetStationWord, tableOrSpeedWord}),
        .dout(wordSync)
    );
    assign targetSync = wordSync[31:16];
    assign speedWordSync = wordSync[15:0];

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [imp_pkg::CTRL_W-1:0] ctrl;
    logic [7:0] division;
    logic [15:0] tlDelay;
    logic [imp_pkg::INT_W-1:0] intStat;
    logic [imp_pkg::INT_W-1:0] intMask;
    logic [imp_pkg::CTRL_W-1:0] next_ctrl;
    logic [7:0] next_division;
    logic [15:0] next_tlDelay;
    logic [imp_pkg::INT_W-1:0] next_intStat;
    logic [imp_pkg::INT_W-1:0] next_intMask;
    logic [31:0] next_prdata;
    logic wrAcc;
    logic mapped;
    logic [imp_pkg::INT_W-1:0] events;
    imp_pkg::imp_state_t state;

    // zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign wrAcc = psel && penable && pwrite;
    assign pslverr = psel && penable && !mapped;
    assign irq = |(intStat & intMask);

    // address decode and read mux, data captured in the setup cycle
    always_comb begin
        mapped = 1'b1;
        next_prdata = prdata;
        unique case (paddr)
            imp_pkg::ADDR_CTRL: next_prdata = 32'(ctrl);
            imp_pkg::ADDR_DIVISION: next_prdata = 32'(division);
            imp_pkg::ADDR_TLDELAY: next_prdata = 32'(tlDelay);
            imp_pkg::ADDR_STATUS: next_prdata = 32'({torqueLimitStop, nextStationWarning,
                inPositionFlag, movementDoneFlag, state});
            imp_pkg::ADDR_INT_STAT: next_prdata = 32'(intStat);
            imp_pkg::ADDR_INT_MASK: next_prdata = 32'(intMask);
            default: begin
                mapped = 1'b0;
                next_prdata = 32'h00000000;
            end
        endcase
        if (!(psel && !penable)) begin
            next_prdata = prdata;
        end
    end

    // writes; a new event beats a write-one clear in the same cycle
    always_comb begin
        next_ctrl = ctrl;
        next_division = division;
        next_tlDelay = tlDelay;
        next_intMask = intMask;
        next_intStat = intStat;
        if (wrAcc && paddr == imp_pkg::ADDR_CTRL) begin
            next_ctrl = pwdata[imp_pkg::CTRL_W-1:0];
        end
        if (wrAcc && paddr == imp_pkg::ADDR_DIVISION) begin
            next_division = pwdata[7:0];
        end
        if (wrAcc && paddr == imp_pkg::ADDR_TLDELAY) begin
            next_tlDelay = pwdata[15:0];
        end
        if (wrAcc && paddr == imp_pkg::ADDR_INT_MASK) begin
            next_intMask = pwdata[imp_pkg::INT_W-1:0];
        end
        if (wrAcc && paddr == imp_pkg::ADDR_INT_STAT) begin
            next_intStat = intStat & ~pwdata[imp_pkg::INT_W-1:0];
        end
        next_intStat = next_intStat | events;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl <= imp_pkg::CTRL_RESET;
            division <= imp_pkg::DIVISION_RESET;
            tlDelay <= imp_pkg::TLDELAY_RESET;
            intStat <= imp_pkg::INT_RESET;
            intMask <= imp_pkg::INT_RESET;
            prdata <= 32'h00000000;
        end else begin
            ctrl <= next_ctrl;
            division <= next_division;
            tlDelay <= next_tlDelay;
            intStat <= next_intStat;
            intMask <= next_intMask;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    imp_pkg::imp_state_t next_state;
    imp_pkg::imp_cmd_t next_cmd;
    logic startPrev;
    logic next_movementDone;
    logic next_inPosition;
    logic next_warning;
    logic startRise;
    logic overRange;
    logic indexerOn;
    logic autoSel;
    logic manualSel;
    logic plainJog;

    assign startRise = fbSync.start && !startPrev;
    assign indexerOn = ctrl[imp_pkg::CTRL_INDEXER];
    assign autoSel = indexerOn && fbSync.modeOne && fbSync.modeTwo;
    assign manualSel = indexerOn && fbSync.modeOne && !fbSync.modeTwo;
    assign plainJog = ctrl[imp_pkg::CTRL_SUBMODE];
    assign overRange = targetSync >= 16'(division);

    // start edges outside idle are dropped and flagged, never queued
    always_comb begin
        next_state = state;
        next_cmd = motionCmd;
        next_movementDone = movementDoneFlag;
        next_warning = overRange;
        next_inPosition = (state == imp_pkg::ST_IDLE) && inRangeAny;
        events = '0;
        events[imp_pkg::INT_WARN] = overRange && !nextStationWarning;
        unique case (state)
            imp_pkg::ST_IDLE: begin
                next_cmd = imp_pkg::CMD_IDLE;
                if (startRise && autoSel && overRange) begin
                    events[imp_pkg::INT_REFUSED] = 1'b1;
                end else if (startRise && autoSel) begin
                    next_state = imp_pkg::ST_AUTO;
                    next_movementDone = 1'b0;
                    next_cmd.active = 1'b1;
                    next_cmd.positioning = 1'b1;
                    next_cmd.station = targetSync[7:0];
                    next_cmd.entry = speedWordSync[7:0];
                    if (ctrl[imp_pkg::CTRL_SPEEDSRC] && ctrl[imp_pkg::CTRL_TWOSTN]) begin
                        next_cmd.directSpeed = 1'b1;
                        next_cmd.speed = speedWordSync;
                        next_cmd.entry = imp_pkg::ENTRY_ONE;
                    end
                end else if (startRise && manualSel) begin
                    // the station and speed words are not read in this branch, so they cannot steer jog
                    next_state = imp_pkg::ST_JOG;
                    next_movementDone = 1'b0;
                    next_cmd.active = 1'b1;
                    next_cmd.entry = imp_pkg::ENTRY_ONE;
                    next_cmd.ccw = ctrl[imp_pkg::CTRL_CCW];
                end
            end
            imp_pkg::ST_AUTO: begin
                events[imp_pkg::INT_REFUSED] = startRise;
                if (servoDone) begin
                    next_state = imp_pkg::ST_IDLE;
                    next_cmd = imp_pkg::CMD_IDLE;
                    next_movementDone = 1'b1;
                    events[imp_pkg::INT_DONE] = 1'b1;
                end
            end
            imp_pkg::ST_JOG: begin
                if (!fbSync.start) begin
                    next_state = imp_pkg::ST_SETTLE;
                    if (plainJog) begin
                        next_cmd.active = 1'b0;
                    end else begin
                        next_cmd.positioning = 1'b1;
                        next_cmd.station = stopStation;
                    end
                end
            end
            imp_pkg::ST_SETTLE: begin
                events[imp_pkg::INT_REFUSED] = startRise;
                if (servoDone) begin
                    next_state = imp_pkg::ST_IDLE;
                    next_cmd = imp_pkg::CMD_IDLE;
                    next_movementDone = 1'b1;
                    events[imp_pkg::INT_DONE] = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= imp_pkg::ST_IDLE;
            motionCmd <= imp_pkg::CMD_IDLE;
            startPrev <= 1'b0;
            movementDoneFlag <= 1'b0;
            inPositionFlag <= 1'b0;
            nextStationWarning <= 1'b0;
        end else begin
            state <= next_state;
            motionCmd <= next_cmd;
            startPrev <= fbSync.start;
            movementDoneFlag <= next_movementDone;
            inPositionFlag <= next_inPosition;
            nextStationWarning <= next_warning;
        end
    end

    // ----------------------------------------
    // stop torque limit after in-position delay
    // ----------------------------------------
    imp_delay_timer #(.TICK(TL_TICK)) u_tl (
        .clk(clk),
        .nrst(nrst),
        .arm(next_inPosition), // one cycle early, so the stop limit falls with in-position
        .delay(tlDelay),
        .expired(torqueLimitStop)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_warn_follows: assert property (overRange |=> nextStationWarning)
        else $error("warning missing for out-of-range station");
    chk_start_ignored: assert property ((state != imp_pkg::ST_IDLE) && startRise
        |=> $stable(motionCmd.station) && !movementDoneFlag)
        else $error("start accepted during movement");
    chk_torque_gate: assert property (torqueLimitStop |-> inPositionFlag)
        else $error("stop torque limit without in-position");
    chk_inpos_idle: assert property ((state == imp_pkg::ST_IDLE) && inRangeAny
        |=> inPositionFlag)
        else $error("in-position not raised at station");
    chk_direct_speed: assert property (motionCmd.directSpeed
        |-> ctrl[imp_pkg::CTRL_TWOSTN] && motionCmd.entry == imp_pkg::ENTRY_ONE)
        else $error("direct speed without two stations");
    chk_jog_entry: assert property ((state == imp_pkg::ST_JOG)
        |-> motionCmd.entry == imp_pkg::ENTRY_ONE && !motionCmd.positioning)
        else $error("jog not using table entry one");
    chk_idx_stop: assert property ((state == imp_pkg::ST_JOG) && !fbSync.start && !plainJog
        |=> state == imp_pkg::ST_SETTLE && motionCmd.positioning
        && motionCmd.station == $past(stopStation))
        else $error("indexer jog did not position to stop station");
    chk_plain_stop: assert property ((state == imp_pkg::ST_JOG) && !fbSync.start && plainJog
        |=> state == imp_pkg::ST_SETTLE && !motionCmd.active)
        else $error("plain jog did not decelerate freely");
    chk_latch_hold: assert property ((state == imp_pkg::ST_AUTO) && $past(state == imp_pkg::ST_AUTO)
        |-> $stable(motionCmd.station) && $stable(motionCmd.speed))
        else $error("latched target changed during movement");
    chk_auto_target: assert property ((state == imp_pkg::ST_IDLE) && startRise && autoSel
        && !overRange |=> motionCmd.station == $past(targetSync[7:0]))
        else $error("target station not taken from word");

    cov_auto_done: cover property ((state == imp_pkg::ST_AUTO) ##[1:50] movementDoneFlag);
    cov_jog_settle: cover property ((state == imp_pkg::ST_JOG) ##1 (state == imp_pkg::ST_SETTLE));
    cov_refused: cover property (events[imp_pkg::INT_REFUSED]);
endmodule

// [tb/imp_master_model.sv]
// fieldbus master and servo stand-in on the far side of the positioning sequencer
`timescale 1ns/10ps
module imp_master_model (
    input wire logic clk,
    input wire imp_pkg::imp_cmd_t motionCmd,
    output logic motionStartBit,
    output logic modeSelectOne,
    output logic modeSelectTwo,
    output logic [15:0] targetStationWord,
    output logic [15:0] tableOrSpeedWord,
    output logic inRangeAny,
    output logic servoDone,
    output logic [7:0] stopStation
);
    int servoLat = 4;
    int cnt = 0;
    logic busy = 1'b0;
    logic lastAct = 1'b0;
    initial begin
        motionStartBit = 1'b0;
        modeSelectOne = 1'b0;
        modeSelectTwo = 1'b0;
        targetStationWord = 16'h0000;
        tableOrSpeedWord = 16'h0000;
        servoDone = 1'b0;
        stopStation = 8'h03;
    end
    // servo: busy from a rise of active, done some cycles after positioning or a stop is commanded
    // busy keys on the rise so the cycle where cmd clears cannot restart it
    always @(posedge clk) begin
        servoDone <= 1'b0;
        lastAct <= motionCmd.active;
        if (servoDone) stopStation <= stopStation + 8'h01;
        if (motionCmd.active && !lastAct) busy <= 1'b1;
        if (busy && (motionCmd.positioning || !motionCmd.active)) begin
            cnt <= cnt + 1;
            if (cnt == servoLat) begin
                servoDone <= 1'b1;
                busy <= 1'b0;
                cnt <= 0;
            end
        end
    end
    // parked on a station whenever stopped, also straight after power-on
    assign inRangeAny = !busy;
    // words and mode bits settle well before start; the link lag cannot split them
    task automatic prep(input logic [15:0] tgt, input logic [15:0] wd, input logic m1,
                        input logic m2);
        @(posedge clk);
        targetStationWord <= tgt;
        tableOrSpeedWord <= wd;
        modeSelectOne <= m1;
        modeSelectTwo <= m2;
        repeat (8) @(posedge clk);
    endtask
    // start is a plain level from the master
    task automatic drive_start(input logic v);
        @(posedge clk);
        motionStartBit <= v;
    endtask
endmodule

// [tb/testbench.sv]
// self-checking bench: automatic moves, refusals, torque delay, interrupts and jogs
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [4:0] ctrl;
        logic [15:0] tgt;
        logic [15:0] wd;
        logic dir;
        logic [7:0] ent;
    } imp_row_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, motionStartBit, modeSelectOne, modeSelectTwo;
    logic [15:0] targetStationWord, tableOrSpeedWord;
    logic inRangeAny, servoDone, movementDoneFlag, inPositionFlag;
    logic nextStationWarning, torqueLimitStop, irq, err;
    logic [7:0] stopStation;
    logic [31:0] r;
    imp_pkg::imp_cmd_t motionCmd;
    int n_errors = 0;
    int n_compared = 0;
    int n;
    imp_row_t rows [4] = '{'{5'h01, 16'h0003, 16'h0002, 1'b0, 8'h02},
        '{5'h19, 16'h0005, 16'h1234, 1'b1, 8'h01}, '{5'h09, 16'h0007, 16'h0005, 1'b0, 8'h05},
        '{5'h11, 16'h0000, 16'h0004, 1'b0, 8'h04}};
    imp_top #(.TL_TICK(4)) u_imp_top (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .motionStartBit(motionStartBit), .modeSelectOne(modeSelectOne),
        .modeSelectTwo(modeSelectTwo), .targetStationWord(targetStationWord),
        .tableOrSpeedWord(tableOrSpeedWord), .inRangeAny(inRangeAny), .servoDone(servoDone),
        .stopStation(stopStation), .motionCmd(motionCmd), .movementDoneFlag(movementDoneFlag),
        .inPositionFlag(inPositionFlag), .nextStationWarning(nextStationWarning),
        .torqueLimitStop(torqueLimitStop), .irq(irq));
    imp_master_model u_imp_master_model (.clk(clk), .motionCmd(motionCmd),
        .motionStartBit(motionStartBit), .modeSelectOne(modeSelectOne),
        .modeSelectTwo(modeSelectTwo), .targetStationWord(targetStationWord),
        .tableOrSpeedWord(tableOrSpeedWord), .inRangeAny(inRangeAny), .servoDone(servoDone),
        .stopStation(stopStation));
    // ----------------------------------------
    // clock and helpers
    // ----------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: probe = motionCmd.active;
            1: probe = movementDoneFlag;
            2: probe = inPositionFlag;
            3: probe = torqueLimitStop;
            default: probe = motionCmd.positioning;
        endcase
    endfunction
    // bounded wait for a level; running out ends the run
    task automatic wait_for(input int k, input logic v, input int lim, output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (probe(k) !== v && c < lim);
        if (probe(k) !== v) begin
            $display("MISMATCH %0t wait ran out", $time);
            n_errors++;
            complete_run();
        end
    endtask
    // one apb transfer: setup, then access until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int c;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pready !== 1'b1 && c < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
        if (c >= 20) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        check(r, e);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        check(32'(motionCmd != imp_pkg::CMD_IDLE), 32'h0);
        check(movementDoneFlag, 1'b0);
        nrst <= 1'b1;
        wait_for(2, 1'b1, 20, n);
        // reset values, then an unmapped place that must be refused
        rd(imp_pkg::ADDR_CTRL, 32'h0);
        rd(imp_pkg::ADDR_DIVISION, 32'h8);
        rd(imp_pkg::ADDR_TLDELAY, 32'h0);
        rd(imp_pkg::ADDR_STATUS, 32'h28);
        rd(imp_pkg::ADDR_INT_STAT, 32'h0);
        rd(imp_pkg::ADDR_INT_MASK, 32'h0);
        rd(8'h20, 32'h0);
        check(err, 1'b1);
        apb(imp_pkg::ADDR_INT_MASK, 1'b1, 32'h1);
        // automatic moves from the remote words, one row each
        for (int i = 0; i < 4; i++) begin
            apb(imp_pkg::ADDR_CTRL, 1'b1, 32'(rows[i].ctrl));
            u_imp_master_model.prep(rows[i].tgt, rows[i].wd, 1'b1, 1'b1);
            check(nextStationWarning, 1'b0);
            u_imp_master_model.drive_start(1'b1);
            wait_for(0, 1'b1, 40, n);
            check(motionCmd.station, rows[i].tgt[7:0]);
            check(motionCmd.positioning, 1'b1);
            check(motionCmd.directSpeed, rows[i].dir);
            check(motionCmd.entry, rows[i].ent);
            if (rows[i].dir) check(motionCmd.speed, rows[i].wd);
            check(movementDoneFlag, 1'b0);
            u_imp_master_model.drive_start(1'b0);
            wait_for(1, 1'b1, 100, n);
        end
        // interrupt raised, then masked, then cleared
        check(irq, 1'b1);
        apb(imp_pkg::ADDR_INT_MASK, 1'b1, 32'h0);
        check(irq, 1'b0);
        apb(imp_pkg::ADDR_INT_STAT, 1'b1, 32'h7);
        rd(imp_pkg::ADDR_INT_STAT, 32'h0);
        // station equal to the division count warns and the start is refused
        u_imp_master_model.prep(16'h0008, 16'h0002, 1'b1, 1'b1);
        check(nextStationWarning, 1'b1);
        u_imp_master_model.drive_start(1'b1);
        repeat (10) @(posedge clk);
        check(motionCmd.active, 1'b0);
        u_imp_master_model.drive_start(1'b0);
        rd(imp_pkg::ADDR_INT_STAT, 32'h6);
        apb(imp_pkg::ADDR_INT_STAT, 1'b1, 32'h7);
        // restart while moving is refused and the latched target holds
        apb(imp_pkg::ADDR_TLDELAY, 1'b1, 32'h2);
        u_imp_master_model.servoLat = 40;
        u_imp_master_model.prep(16'h0002, 16'h0003, 1'b1, 1'b1);
        u_imp_master_model.drive_start(1'b1);
        wait_for(0, 1'b1, 40, n);
        u_imp_master_model.drive_start(1'b0);
        u_imp_master_model.prep(16'h0005, 16'h0004, 1'b1, 1'b1);
        u_imp_master_model.drive_start(1'b1);
        repeat (8) @(posedge clk);
        check(motionCmd.station, 8'h02);
        check(motionCmd.entry, 8'h03);
        rd(imp_pkg::ADDR_INT_STAT, 32'h4);
        u_imp_master_model.drive_start(1'b0);
        wait_for(1, 1'b1, 100, n);
        u_imp_master_model.servoLat = 4;
        // stop torque limit follows in-position after two units of four cycles
        wait_for(2, 1'b1, 10, n);
        wait_for(3, 1'b1, 20, n);
        check(n >= 8 && n <= 11, 1'b1);
        // indexer jog with reversed numbering, then plain jog
        for (int j = 0; j < 2; j++) begin
            apb(imp_pkg::ADDR_CTRL, 1'b1, j == 0 ? 32'h5 : 32'h3);
            u_imp_master_model.prep(16'h0001, 16'h0006, 1'b1, 1'b0);
            u_imp_master_model.drive_start(1'b1);
            wait_for(0, 1'b1, 40, n);
            check(motionCmd.positioning, 1'b0);
            check(motionCmd.entry, imp_pkg::ENTRY_ONE);
            check(motionCmd.ccw, j == 0);
            u_imp_master_model.drive_start(1'b0);
            if (j == 0) begin
                wait_for(4, 1'b1, 40, n);
                check(motionCmd.station, stopStation);
            end else begin
                wait_for(0, 1'b0, 40, n);
                check(movementDoneFlag, 1'b0);
            end
            wait_for(1, 1'b1, 100, n);
        end
        // manual mode bits without indexer operation selected must not move
        apb(imp_pkg::ADDR_CTRL, 1'b1, 32'h0);
        u_imp_master_model.prep(16'h0001, 16'h0002, 1'b1, 1'b0);
        u_imp_master_model.drive_start(1'b1);
        repeat (10) @(posedge clk);
        check(motionCmd.active, 1'b0);
        // reset in mid-run clears the done flag, in-position returns after it
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        check(movementDoneFlag, 1'b0);
        nrst <= 1'b1;
        wait_for(2, 1'b1, 20, n);
        complete_run();
    end
endmodule
